// [hdl/ctl_arith_pkg.sv]
// shared constants, types and register map of the control and arithmetic core
package ctl_arith_pkg;

  // clock and machine cycle timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned T_OPCODE      = 4;
  localparam int unsigned T_MEMREAD     = 3;
  localparam logic [1:0]  T_OP_LAST     = 2'(T_OPCODE - 1);
  localparam logic [1:0]  T_MR_LAST     = 2'(T_MEMREAD - 1);

  // opcodes of the group and the restart address
  localparam logic [7:0] OP_INVERT_ACCUM = 8'h2F;
  localparam logic [7:0] OP_FLIP_BORROW  = 8'h3F;
  localparam logic [7:0] OP_FORCE_BORROW = 8'h37;
  localparam logic [7:0] OP_IDLE         = 8'h00;
  localparam logic [7:0] OP_STALL        = 8'h76;
  localparam logic [7:0] OP_MASK_OFF     = 8'hF3;
  localparam logic [7:0] OP_MASK_ON      = 8'hFB;
  localparam logic [7:0] OP_PREFIX       = 8'hED;
  localparam logic [7:0] OP2_TWOS_COMP   = 8'h44;
  localparam logic [7:0] OP2_SCHEME0     = 8'h46;
  localparam logic [7:0] OP2_SCHEME1     = 8'h56;
  localparam logic [7:0] OP2_SCHEME2     = 8'h5E;
  localparam logic [15:0] RESTART_ADDR   = 16'h0038;

  // flag bit positions
  localparam int unsigned F_SIGN   = 7;
  localparam int unsigned F_ZERO   = 6;
  localparam int unsigned F_NIBBLE = 4;
  localparam int unsigned F_PARITY = 2;
  localparam int unsigned F_SUB    = 1;
  localparam int unsigned F_BORROW = 0;

  // apb register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_ACCUM   = 8'h04;
  localparam logic [7:0] REG_FLAGS   = 8'h08;
  localparam logic [7:0] REG_PC      = 8'h0C;
  localparam logic [7:0] REG_VPAGE   = 8'h10;
  localparam logic [7:0] REG_STATUS  = 8'h14;
  localparam logic [7:0] REG_RETADDR = 8'h18;

  // reset values and the defer setting loaded on mask on
  localparam logic [7:0]  RST_ACCUM = 8'hFF;
  localparam logic [7:0]  RST_FLAGS = 8'hFF;
  localparam logic [15:0] RST_PC    = 16'h0000;
  localparam logic [1:0]  RST_DEFER = 2'h0;
  localparam logic [1:0]  DEFER_SET = 2'h2;

  typedef enum logic [4:0] {
    ST_FETCH  = 5'b00001,
    ST_PREFIX = 5'b00010,
    ST_ACK    = 5'b00100,
    ST_VEC_LO = 5'b01000,
    ST_VEC_HI = 5'b10000
  } cyc_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic        m1;
    logic        ack;
    logic        rfsh;
  } mem_req_t;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] flags;
    logic       stall;
    logic       mask_on;
    logic       mask_off;
    logic       prefix;
  } exec_t;

endpackage

// [hdl/ctl_arith_core.sv]
// control and arithmetic instruction core with apb register access
// Function
// - opcode 2F inverts accumulator, four states
// - inversion sets nibble and subtract flags only
// - ED 44 negates accumulator, eight states
// - negate flags: overflow 80h, borrow nonzero
// - 3F flips borrow, old borrow to nibble
// - force borrow sets borrow, clears nibble, subtract
// - idle changes nothing, one machine cycle
// - opcode 76 stalls until interrupt or reset
// - stalled core keeps running refresh opcode cycles
// - F3 clears both mask gates
// - mask off blocks interrupt during itself
// - masked request ignored until mask on
// - mask on sets both mask gates
// - no acceptance during mask on or next
// - ED 46 selects scheme 0, bus opcode
// - scheme 0 first byte on acknowledge
// - ED 56 selects scheme 1, restart 0038h
// - ED 5E scheme 2, vector page pointer
// - scheme 2 reads service address from table
`timescale 1ns/1ps
module ctl_arith_core
  import ctl_arith_pkg::*;
#(
  parameter int unsigned RFSH_W = 7
)(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // memory and peripheral bus
  output mem_req_t         mem_req,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        int_req_n,
  // core state
  output logic             stalled
);

  // refresh address byte has room for at most eight counter bits
  if (RFSH_W < 1 || RFSH_W > 8)
  begin
    $error("refresh width must be 1 to 8");
  end

  typedef struct packed {
    cyc_t              cyc;
    logic [1:0]        tcnt;
    logic              run;
    logic [7:0]        acc;
    logic [7:0]        flags;
    logic [15:0]       pc;
    logic [7:0]        vpage;
    logic [7:0]        vec;
    logic [7:0]        tbl_lo;
    logic [15:0]       ret;
    logic              gate_one;
    logic              gate_two;
    logic [1:0]        scheme;
    logic [1:0]        defer;
    logic              halted;
    logic [RFSH_W-1:0] rfsh_cnt;
    logic [7:0]        din_s1;
    logic [7:0]        din_s2;
    logic              irq_s1;
    logic              irq_s2;
    mem_req_t          bus;
    logic [31:0]       rdata;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  // unprefixed opcode execution, shared by fetch and scheme 0 acknowledge
  function automatic exec_t exec_op(input logic [7:0] op, input logic [7:0] a,
                                    input logic [7:0] f);
    exec_t r;
    r          = '0;
    r.acc      = a;
    r.flags    = f;
    unique case (op)
      OP_INVERT_ACCUM:
      begin
        r.acc              = ~a;
        r.flags[F_NIBBLE]  = 1'b1;
        r.flags[F_SUB]     = 1'b1;
      end
      OP_FLIP_BORROW:
      begin
        r.flags[F_BORROW]  = ~f[F_BORROW];
        r.flags[F_NIBBLE]  = f[F_BORROW];
        r.flags[F_SUB]     = 1'b0;
      end
      OP_FORCE_BORROW:
      begin
        r.flags[F_BORROW]  = 1'b1;
        r.flags[F_NIBBLE]  = 1'b0;
        r.flags[F_SUB]     = 1'b0;
      end
      OP_STALL:    r.stall    = 1'b1;
      OP_MASK_OFF: r.mask_off = 1'b1;
      OP_MASK_ON:  r.mask_on  = 1'b1;
      OP_PREFIX:   r.prefix   = 1'b1;
      default:     r.acc      = a;
    endcase
    return r;
  endfunction

  // address decode, used by read and write paths
  function automatic logic addr_hit(input logic [31:0] addr);
    return (addr[31:8] == 24'h000000) && (addr[1:0] == 2'b00) &&
           (addr[7:0] <= REG_RETADDR);
  endfunction

  // bus outputs derived from the cycle the core is about to enter
  function automatic mem_req_t bus_for(input state_t s);
    mem_req_t b;
    logic     early;
    b     = '0;
    early = (s.tcnt < 2'd2);
    if (s.run)
    begin
      b.addr = s.pc;
      unique case (s.cyc)
        ST_FETCH, ST_PREFIX:
        begin
          b.rd   = early;
          b.m1   = early;
          b.rfsh = !early;
          if (!early)
            b.addr = {s.vpage, 8'(s.rfsh_cnt)};
        end
        ST_ACK:
        begin
          b.m1  = early;
          b.ack = early;
        end
        ST_VEC_LO:
        begin
          b.rd   = early;
          b.addr = {s.vpage, s.vec};
        end
        ST_VEC_HI:
        begin
          b.rd   = early;
          b.addr = 16'({s.vpage, s.vec} + 16'h0001);
        end
      endcase
    end
    return b;
  endfunction

  always_comb
  begin
    exec_t  ex;
    logic   done;
    logic   wr;
    logic   accept;
    logic [7:0] neg;
    ex     = '0;
    done   = 1'b0;
    accept = 1'b0;
    neg    = 8'h00;
    nxt_st = st_ff;
    wr     = psel && penable && addr_hit(paddr);

    // input synchronisers
    nxt_st.din_s1 = mem_rdata;
    nxt_st.din_s2 = st_ff.din_s1;
    nxt_st.irq_s1 = int_req_n;
    nxt_st.irq_s2 = st_ff.irq_s1;

    if (st_ff.run)
    begin
      nxt_st.tcnt = 2'(st_ff.tcnt + 2'd1);
      unique case (st_ff.cyc)
        ST_FETCH:
        begin
          if (st_ff.tcnt == 2'd2)
            nxt_st.rfsh_cnt = RFSH_W'(st_ff.rfsh_cnt + 1'b1);
          if (st_ff.tcnt == T_OP_LAST)
          begin
            nxt_st.tcnt = 2'd0;
            if (st_ff.halted)
            begin
              // stalled cycles run as idle so that acc and flags keep their values
              ex   = exec_op(OP_IDLE, st_ff.acc, st_ff.flags);
              done = 1'b1;
            end
            else
            begin
              nxt_st.pc = 16'(st_ff.pc + 16'h0001);
              ex        = exec_op(st_ff.din_s2, st_ff.acc, st_ff.flags);
              done      = 1'b1;
            end
          end
        end
        ST_ACK:
        begin
          if (st_ff.tcnt == T_OP_LAST)
          begin
            nxt_st.tcnt = 2'd0;
            nxt_st.vec  = st_ff.din_s2;
            nxt_st.cyc  = ST_FETCH;
            unique case (st_ff.scheme)
              2'd1:
              begin
                nxt_st.pc = RESTART_ADDR;
              end
              2'd2, 2'd3:
              begin
                nxt_st.cyc = ST_VEC_LO;
              end
              default:
              begin
                ex   = exec_op(st_ff.din_s2, st_ff.acc, st_ff.flags);
                done = 1'b1;
              end
            endcase
          end
        end
        ST_PREFIX:
        begin
          if (st_ff.tcnt == 2'd2)
            nxt_st.rfsh_cnt = RFSH_W'(st_ff.rfsh_cnt + 1'b1);
          if (st_ff.tcnt == T_OP_LAST)
          begin
            nxt_st.tcnt = 2'd0;
            nxt_st.pc   = 16'(st_ff.pc + 16'h0001);
            nxt_st.cyc  = ST_FETCH;
            done        = 1'b1;
            unique case (st_ff.din_s2)
              OP2_TWOS_COMP:
              begin
                neg                    = 8'(8'h00 - st_ff.acc);
                nxt_st.acc             = neg;
                nxt_st.flags[F_SIGN]   = neg[7];
                nxt_st.flags[F_ZERO]   = (neg == 8'h00);
                nxt_st.flags[F_NIBBLE] = (st_ff.acc[3:0] != 4'h0);
                nxt_st.flags[F_PARITY] = (st_ff.acc == 8'h80);
                nxt_st.flags[F_SUB]    = 1'b1;
                nxt_st.flags[F_BORROW] = (st_ff.acc != 8'h00);
              end
              OP2_SCHEME0: nxt_st.scheme = 2'd0;
              OP2_SCHEME1: nxt_st.scheme = 2'd1;
              OP2_SCHEME2: nxt_st.scheme = 2'd2;
              default:     nxt_st.scheme = st_ff.scheme;
            endcase
          end
        end
        ST_VEC_LO:
        begin
          if (st_ff.tcnt == T_MR_LAST)
          begin
            nxt_st.tcnt   = 2'd0;
            nxt_st.tbl_lo = st_ff.din_s2;
            nxt_st.cyc    = ST_VEC_HI;
          end
        end
        ST_VEC_HI:
        begin
          if (st_ff.tcnt == T_MR_LAST)
          begin
            nxt_st.tcnt = 2'd0;
            nxt_st.pc   = {st_ff.din_s2, st_ff.tbl_lo};
            nxt_st.cyc  = ST_FETCH;
          end
        end
      endcase
    end

    // results of an unprefixed opcode
    if (done && st_ff.cyc != ST_PREFIX)
    begin
      nxt_st.acc   = ex.acc;
      nxt_st.flags = ex.flags;
      if (ex.stall)
        nxt_st.halted = 1'b1;
      if (ex.mask_off)
      begin
        nxt_st.gate_one = 1'b0;
        nxt_st.gate_two = 1'b0;
      end
      if (ex.mask_on)
      begin
        nxt_st.gate_one = 1'b1;
        nxt_st.gate_two = 1'b1;
      end
      if (ex.prefix)
      begin
        nxt_st.cyc = ST_PREFIX;
        done       = 1'b0;
      end
    end

    // instruction boundary: interrupt acceptance
    if (done)
    begin
      nxt_st.cyc = ST_FETCH;
      if (st_ff.defer != 2'd0)
        nxt_st.defer = 2'(st_ff.defer - 2'd1);
      if (ex.mask_on)
        nxt_st.defer = DEFER_SET - 2'd1;
      // acceptance opens at the end of the instruction after mask on
      accept     = nxt_st.gate_one && !st_ff.irq_s2 && (nxt_st.defer == 2'd0)
                   && !ex.mask_on;
      if (accept)
      begin
        nxt_st.cyc      = ST_ACK;
        nxt_st.halted   = 1'b0;
        nxt_st.ret      = nxt_st.pc;
        nxt_st.gate_one = 1'b0;
        nxt_st.gate_two = 1'b0;
      end
    end

    // apb writes; core state only while stopped
    if (wr && pwrite && pstrb[0])
    begin
      unique case (paddr[7:0])
        REG_CTRL: nxt_st.run = pwdata[0];
        REG_ACCUM:
          if (!st_ff.run)
            nxt_st.acc = pwdata[7:0];
        REG_FLAGS:
          if (!st_ff.run)
            nxt_st.flags = pwdata[7:0];
        REG_PC:
          if (!st_ff.run)
            nxt_st.pc = pwdata[15:0];
        REG_VPAGE:
          if (!st_ff.run)
            nxt_st.vpage = pwdata[7:0];
        default: nxt_st.run = st_ff.run;
      endcase
    end
    if (!nxt_st.run)
    begin
      nxt_st.cyc  = ST_FETCH;
      nxt_st.tcnt = 2'd0;
    end

    // read data captured in the setup phase
    nxt_st.rdata = 32'h00000000;
    if (psel && !penable && !pwrite)
    begin
      unique case (paddr[7:0])
        REG_CTRL:    nxt_st.rdata = {31'h00000000, st_ff.run};
        REG_ACCUM:   nxt_st.rdata = {24'h000000, st_ff.acc};
        REG_FLAGS:   nxt_st.rdata = {24'h000000, st_ff.flags};
        REG_PC:      nxt_st.rdata = {16'h0000, st_ff.pc};
        REG_VPAGE:   nxt_st.rdata = {24'h000000, st_ff.vpage};
        REG_STATUS:  nxt_st.rdata = {16'h0000, 3'h0, st_ff.cyc, 1'b0, st_ff.defer,
                                     st_ff.scheme, st_ff.gate_two, st_ff.gate_one,
                                     st_ff.halted};
        REG_RETADDR: nxt_st.rdata = {16'h0000, st_ff.ret};
        default:     nxt_st.rdata = 32'h00000000;
      endcase
    end

    nxt_st.bus = bus_for(nxt_st);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff          <= '0;
      st_ff.cyc      <= ST_FETCH;
      st_ff.acc      <= RST_ACCUM;
      st_ff.flags    <= RST_FLAGS;
      st_ff.pc       <= RST_PC;
      st_ff.defer    <= RST_DEFER;
      st_ff.din_s1   <= 8'hFF;
      st_ff.din_s2   <= 8'hFF;
      st_ff.irq_s1   <= 1'b1;
      st_ff.irq_s2   <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  assign prdata  = st_ff.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_hit(paddr);
  assign mem_req = st_ff.bus;
  assign stalled = st_ff.halted;

endmodule

// [tb/ctl_arith_props.sv]
// concurrent checks on the core bus timing and interrupt gating
`timescale 1ns/1ps
module ctl_arith_props
  import ctl_arith_pkg::*;
(
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // apb select
  input wire logic       psel,
  // memory and peripheral bus
  input wire mem_req_t   mem_req,
  input wire logic [7:0] mem_rdata,
  input wire logic       int_req_n,
  // core state
  input wire logic       stalled
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic m1_q;
  logic fetch;

  // first state of an opcode fetch
  assign fetch = mem_req.m1 && mem_req.rd && !m1_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      m1_q <= 1'b0;
    else
      m1_q <= mem_req.m1;
  end

  chk_fetch_shape:
    assert property (fetch |=> mem_req.m1 ##1 (mem_req.rfsh && !mem_req.m1) ##1 mem_req.rfsh)
    else $error("opcode fetch shape wrong");
  chk_stall_enter:
    assert property (fetch && mem_rdata == OP_STALL |-> ##[1:8] stalled)
    else $error("stall opcode did not stall");
  chk_stall_hold:
    assert property ((stalled && int_req_n && !psel) [*4] |=> stalled)
    else $error("stall left without interrupt");
  chk_stall_rfsh:
    assert property (stalled && fetch |-> ##2 (mem_req.rfsh && !mem_req.rd))
    else $error("no refresh while stalled");
  chk_ack_shape:
    assert property ($rose(mem_req.ack) |-> mem_req.m1 && !mem_req.rd ##1 mem_req.ack ##1 !mem_req.ack)
    else $error("acknowledge cycle shape wrong");
  chk_prefix_pair:
    assert property (fetch && mem_rdata == OP_PREFIX |-> ##4 fetch)
    else $error("prefix not followed by second fetch");
  chk_mask_on_defer:
    assert property (fetch && mem_rdata == OP_MASK_ON |-> !mem_req.ack [*8])
    else $error("interrupt taken too early after mask on");
  chk_mask_off_block:
    assert property (fetch && mem_rdata == OP_MASK_OFF |-> !mem_req.ack [*8])
    else $error("interrupt taken after mask off");
endmodule

bind ctl_arith_core ctl_arith_props u_props (
  .pclk, .presetn, .psel, .mem_req, .mem_rdata, .int_req_n, .stalled
);

// [tb/mem_periph_model.sv]
// memory and interrupting peripheral on the far side of the core bus
`timescale 1ns/1ps
module mem_periph_model
  import ctl_arith_pkg::*;
(
  // clock
  input  wire logic       pclk,
  // bus from core
  input  wire mem_req_t   mem_req,
  // data to core
  output logic      [7:0] mem_rdata
);
  logic [7:0] mem [0:4095];
  logic [7:0] vec = 8'h00;
  logic [7:0] last_ff = 8'h00;

  // released bus shows a changing pattern, not the last byte
  always_comb
  begin
    if (mem_req.ack)
      mem_rdata = vec;
    else if (mem_req.rd)
      mem_rdata = mem[mem_req.addr[11:0]];
    else
      mem_rdata = ~last_ff;
  end

  always_ff @(posedge pclk)
    last_ff <= mem_rdata;
endmodule

// [tb/tb_cpu_control_arith_group.sv]
// self-checking bench for the control and arithmetic core
`timescale 1ns/1ps
module tb_cpu_control_arith_group;
  import ctl_arith_pkg::*;
  `define CHK(g, e, m) \
    begin n_checks++; \
      if ((g) !== (e)) begin err_count++; $display("BAD %0t %s", $time, m); end end

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  mem_req_t    mem_req;
  logic [7:0]  mem_rdata;
  logic        int_req_n = 1'b1;
  logic        stalled;
  logic [31:0] rd_q;
  logic        err_q;
  int          err_count = 0;
  int          n_checks = 0;
  // op, second byte, acc in, flags in, acc out, documented flags out
  logic [47:0] tbl [8] = '{48'h2F00B4C54BD7, 48'hED4498006813, 48'hED4480008087,
                           48'hED4400FF0042, 48'h3F0011C711D4, 48'h3F0022022201,
                           48'h370033D633C5, 48'h00005AC75AC7};

  ctl_arith_core dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
    .prdata, .pready, .pslverr, .mem_req, .mem_rdata, .int_req_n, .stalled
  );
  mem_periph_model u_mem (.pclk, .mem_req, .mem_rdata);

  initial
    forever #(CLK_PERIOD_NS / 2) pclk = ~pclk;

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {24'h0, a};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd_q = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_st(input logic v);
    int i;
    i = 0;
    while (stalled !== v && i < 300)
    begin
      @(posedge pclk);
      i++;
    end
    `CHK(stalled, v, "stall state")
  endtask

  task automatic load(input logic [39:0] p);
    for (int i = 0; i < 5; i++)
      u_mem.mem[i] = p[39 - 8 * i -: 8];
  endtask

  // reset, preset registers, run until the core stalls
  task automatic go(input logic [7:0] a, input logic [7:0] f, input logic [7:0] vp);
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, REG_ACCUM, {24'h0, a});
    apb(1'b1, REG_FLAGS, {24'h0, f});
    apb(1'b1, REG_VPAGE, {24'h0, vp});
    apb(1'b1, REG_CTRL, 32'h1);
    wait_st(1'b1);
  endtask

  // stop, check flags and status, leave return address in rd_q
  task automatic wrap(input logic [7:0] ef, input logic [3:0] es);
    apb(1'b1, REG_CTRL, 32'h0);
    apb(1'b0, REG_FLAGS, 32'h0);
    `CHK(rd_q[7:0] & 8'hD7, ef, "flags after interrupt")
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK(rd_q[4:1], es, "scheme and gates")
    apb(1'b0, REG_RETADDR, 32'h0);
  endtask

  initial
  begin
    #(CLK_PERIOD_NS * 50000);
    err_count++;
    conclude;
  end

  initial
  begin
    for (int i = 0; i < 4096; i++)
      u_mem.mem[i] = 8'h00;
    foreach (tbl[k])
    begin
      load({tbl[k][47:32], OP_STALL, 16'h0000});
      go(tbl[k][31:24], tbl[k][23:16], 8'h00);
      apb(1'b1, REG_CTRL, 32'h0);
      apb(1'b0, REG_ACCUM, 32'h0);
      `CHK(rd_q, {24'h0, tbl[k][15:8]}, "accumulator")
      apb(1'b0, REG_FLAGS, 32'h0);
      `CHK(rd_q[7:0] & 8'hD7, tbl[k][7:0], "flags")
    end
    $display("arithmetic table done");
    // interrupt wakes the stalled core, restart vector
    load(40'hED56FB7600);
    u_mem.mem[12'h038] = OP_STALL;
    go(8'h00, 8'h00, 8'h00);
    int_req_n <= 1'b0;
    wait_st(1'b0);
    wait_st(1'b1);
    int_req_n <= 1'b1;
    wrap(8'h00, 4'b0100);
    $display("restart scheme done");
    // vectored scheme with request pending through mask on
    load(40'hED5EFB0076);
    u_mem.vec = 8'h40;
    u_mem.mem[12'h140] = 8'h80;
    u_mem.mem[12'h141] = 8'h00;
    u_mem.mem[12'h080] = OP_STALL;
    int_req_n <= 1'b0;
    go(8'h00, 8'h00, 8'h01);
    wrap(8'h00, 4'b1000);
    `CHK(rd_q[15:0], 16'h0004, "vectored return address")
    $display("vectored scheme done");
    // bus opcode scheme runs the peripheral byte
    load(40'hED46FB0076);
    u_mem.vec = OP_FORCE_BORROW;
    go(8'h00, 8'h00, 8'h00);
    wrap(8'h01, 4'b0000);
    `CHK(rd_q[15:0], 16'h0004, "bus opcode return address")
    $display("bus opcode scheme done");
    // mask off right after mask on keeps the request out
    load(40'hFBF3007600);
    go(8'h00, 8'h00, 8'h00);
    wrap(8'h00, 4'b0000);
    int_req_n <= 1'b1;
    $display("interrupt schemes done");
    apb(1'b0, 8'h40, 32'h0);
    `CHK(err_q, 1'b1, "unmapped error")
    `CHK(rd_q, 32'h0, "unmapped data")
    $display("register map done");
    conclude;
  end
endmodule
